// ===== shared/flags_decoder_consts.vh
`ifndef FLAGS_DECODER_CONSTS_VH
`define FLAGS_DECODER_CONSTS_VH

// ---------------------------------------------------------------
// descriptor flag field positions
// ---------------------------------------------------------------
`define FLG_OPSPEC_HI     23
`define FLG_OPSPEC_LO     16
`define FLG_RSVD_BIT      15
`define FLG_CACHE_CTL2    14
`define FLG_STRICT_ORDER  13
`define FLG_CR_TC_SEL     12
`define FLG_ADDR3_TC_SEL  11
`define FLG_ADDR2_TC_SEL  10

// ---------------------------------------------------------------
// operation codes
// ---------------------------------------------------------------
`define OP_NOOP           8'h00
`define OP_BATCH          8'h01
`define OP_DRAIN          8'h02
`define OP_MEM_MOVE       8'h03
`define OP_FILL           8'h04
`define OP_COMPARE        8'h05
`define OP_COMPARE_PAT    8'h06
`define OP_CREATE_DELTA   8'h07
`define OP_APPLY_DELTA    8'h08
`define OP_DUALCAST       8'h09
`define OP_XLAT_FETCH     8'h0A
`define OP_CRC_GEN        8'h10
`define OP_COPY_CRC       8'h11
`define OP_DIF_CHECK      8'h12
`define OP_DIF_INSERT     8'h13
`define OP_DIF_STRIP      8'h14
`define OP_DIF_UPDATE     8'h15
`define OP_DIX_GEN        8'h17
`define OP_TYPE_CONV      8'h18
`define OP_REDUCE         8'h19
`define OP_REDUCE_DUAL    8'h1A
`define OP_GATHER_REDUCE  8'h1B
`define OP_GATHER_COPY    8'h1C
`define OP_SCATTER_COPY   8'h1D
`define OP_SCATTER_FILL   8'h1E
`define OP_CACHE_FLUSH    8'h20
`define OP_UPDATE_WINDOW  8'h21
`define OP_IDOM_COPY      8'h23
`define OP_IDOM_FILL      8'h24
`define OP_IDOM_COMPARE   8'h25
`define OP_IDOM_CMP_PAT   8'h26

// ---------------------------------------------------------------
// register map (byte addresses) and fields
// ---------------------------------------------------------------
`define ADDR_W            8
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_COUNT         8'h08
`define REG_GRP_BASE      8'h40
`define REG_GRP_MASK      8'hE0
`define CTRL_RELAX_EN     0
`define STAT_RSVD_VIOL    0
`define CTRL_RESET        1'h1
`define TC_W              3
`define WQ_W              3
`define WQ_NUM            8
`define GRP_FIRST_LO      0
`define GRP_SECOND_LO     4
`define COUNT_W           16

`endif

// ===== hdl/group_tc_table.v
`timescale 1ns/1ns
`include "flags_decoder_consts.vh"

// per work_queue group traffic-class pair store, two registered read ports
module group_tc_table (
  input  wire                clk,       // core clock
  input  wire                wr_en,     // write one entry
  input  wire [`WQ_W-1:0]    wr_idx,    // entry written
  input  wire [2*`TC_W-1:0]  wr_val,    // {second, first}
  input  wire [`WQ_W-1:0]    a_idx,     // decode port index
  output reg  [2*`TC_W-1:0]  a_val,     // decode port data
  input  wire [`WQ_W-1:0]    b_idx,     // bus port index
  output reg  [2*`TC_W-1:0]  b_val      // bus port data
);

  reg [2*`TC_W-1:0] mem [0:`WQ_NUM-1];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // write and both reads registered; a read of the written entry sees old data
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_val;
    a_val <= mem[a_idx];
    b_val <= mem[b_idx];
  end

endmodule // group_tc_table

// ===== hdl/descriptor_flags_decoder.v
`timescale 1ns/1ns
`include "flags_decoder_consts.vh"

module descriptor_flags_decoder (
  input  wire                 clk,             // core clock
  input  wire                 rst,             // synchronous reset, active high
  input  wire [`ADDR_W-1:0]   reg_addr,        // register byte address
  input  wire [31:0]          reg_wdata,       // register write data
  input  wire                 reg_wr,          // write strobe
  input  wire                 reg_rd,          // read strobe
  output wire [31:0]          reg_rdata,       // read data, cycle after strobe
  input  wire                 desc_valid,      // descriptor word presented
  input  wire [63:0]          desc_word0,      // first 8 bytes of descriptor
  input  wire                 cr_addr_valid,   // completion record address valid
  input  wire                 read_seed,       // read crc seed option
  input  wire [`WQ_W-1:0]     work_queue,      // receiving work queue
  output reg                  out_valid,       // decode result pulse
  output reg  [7:0]           out_opcode,      // decoded operation
  output reg  [7:0]           out_op_flags,    // operation specific flags
  output reg                  out_cache_ctl2,  // cache placement hint bit
  output reg                  out_strict,      // all writes strictly ordered
  output reg                  out_cr_fenced,   // completion write after dest writes
  output reg                  out_cr_tc_used,  // completion class meaningful
  output reg  [`TC_W-1:0]     out_cr_tc,       // completion record class
  output reg                  out_a3_tc_used,  // third address class meaningful
  output reg  [`TC_W-1:0]     out_a3_tc,       // third address class
  output reg                  out_a2_tc_used,  // second address class meaningful
  output reg  [`TC_W-1:0]     out_a2_tc        // second address class
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg                   relax_en;
  reg                   rsvd_viol;
  reg [`COUNT_W-1:0]    desc_count;
  reg [31:0]            rd_reg;
  reg                   rd_from_table;
  wire [2*`TC_W-1:0]    tbl_a;
  wire [2*`TC_W-1:0]    tbl_b;

  // register decode: control, status, and one hit for all eight group words
  wire ctrl_hit   = (reg_addr == `REG_CTRL);
  wire status_hit = (reg_addr == `REG_STATUS);
  wire grp_hit = ((reg_addr & `REG_GRP_MASK) == `REG_GRP_BASE) && (reg_addr[1:0] == 2'h0);
  wire [`WQ_W-1:0] grp_idx = reg_addr[`WQ_W+1:2];
  wire tbl_wr = reg_wr && grp_hit;
  wire [2*`TC_W-1:0] tbl_wval = {reg_wdata[`GRP_SECOND_LO+`TC_W-1:`GRP_SECOND_LO],
                                 reg_wdata[`GRP_FIRST_LO+`TC_W-1:`GRP_FIRST_LO]};

  // ---------------------------------------------------------------
  // decode pipeline stage 1
  // ---------------------------------------------------------------
  reg         s1_valid;
  reg [7:0]   s1_op;
  reg [23:0]  s1_flags;
  reg         s1_crav;
  reg         s1_seed;

  // fields of the first descriptor word
  wire [7:0]  in_op    = desc_word0[63:56];
  wire [23:0] in_flags = desc_word0[55:32];

  // group table shared by decode and bus readback
  group_tc_table u_tbl (
    .clk    (clk),
    .wr_en  (tbl_wr),
    .wr_idx (grp_idx),
    .wr_val (tbl_wval),
    .a_idx  (work_queue),
    .a_val  (tbl_a),
    .b_idx  (grp_idx),
    .b_val  (tbl_b)
  );

  // capture the descriptor while its group entry is read; strictly in order
  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_valid <= 1'b0;
      s1_op    <= 8'h00;
      s1_flags <= 24'h000000;
      s1_crav  <= 1'b0;
      s1_seed  <= 1'b0;
    end
    else
    begin
      s1_valid <= desc_valid;
      if (desc_valid)
      begin
        s1_op    <= in_op;
        s1_flags <= in_flags;
        s1_crav  <= cr_addr_valid;
        s1_seed  <= read_seed;
      end
    end
  end

  // ---------------------------------------------------------------
  // operation classification
  // ---------------------------------------------------------------
  // operations that write memory besides the completion record
  function writes_mem;
    input [7:0] op;
    begin
      case (op)
        `OP_MEM_MOVE, `OP_FILL, `OP_CREATE_DELTA, `OP_APPLY_DELTA, `OP_DUALCAST,
        `OP_COPY_CRC, `OP_DIF_INSERT, `OP_DIF_STRIP, `OP_DIF_UPDATE, `OP_DIX_GEN,
        `OP_TYPE_CONV, `OP_REDUCE, `OP_REDUCE_DUAL, `OP_GATHER_REDUCE,
        `OP_GATHER_COPY, `OP_SCATTER_COPY, `OP_SCATTER_FILL, `OP_IDOM_COPY,
        `OP_IDOM_FILL:
          writes_mem = 1'b1;
        default:
          writes_mem = 1'b0;
      endcase
    end
  endfunction

  // operations whose third address class is defined
  function a3_defined;
    input [7:0] op;
    input       seed;
    begin
      case (op)
        `OP_DUALCAST, `OP_CREATE_DELTA, `OP_REDUCE, `OP_REDUCE_DUAL,
        `OP_GATHER_REDUCE, `OP_GATHER_COPY, `OP_SCATTER_COPY, `OP_SCATTER_FILL:
          a3_defined = 1'b1;
        `OP_CRC_GEN, `OP_COPY_CRC:
          a3_defined = seed;
        default:
          a3_defined = 1'b0;
      endcase
    end
  endfunction

  // operations whose second address class is defined
  function a2_defined;
    input [7:0] op;
    begin
      case (op)
        `OP_MEM_MOVE, `OP_FILL, `OP_APPLY_DELTA, `OP_COPY_CRC, `OP_DIF_INSERT,
        `OP_DIF_STRIP, `OP_DIF_UPDATE, `OP_DIX_GEN, `OP_TYPE_CONV,
        `OP_GATHER_REDUCE, `OP_GATHER_COPY, `OP_IDOM_COPY, `OP_IDOM_FILL:
          a2_defined = 1'b1;
        `OP_DRAIN, `OP_DUALCAST, `OP_COMPARE, `OP_CREATE_DELTA, `OP_REDUCE,
        `OP_REDUCE_DUAL, `OP_SCATTER_COPY, `OP_SCATTER_FILL:
          a2_defined = 1'b1;
        default:
          a2_defined = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // decode stage 2: class selection and ordering
  // ---------------------------------------------------------------
  wire [`TC_W-1:0] tc_first  = tbl_a[`TC_W-1:0];
  wire [`TC_W-1:0] tc_second = tbl_a[2*`TC_W-1:`TC_W];
  wire s1_wr   = writes_mem(s1_op);
  wire cr_use  = s1_crav;
  wire a3_use  = a3_defined(s1_op, s1_seed);
  wire a2_use  = a2_defined(s1_op);

  reg              next_strict;
  wire [`TC_W-1:0] next_cr_tc;
  wire [`TC_W-1:0] next_a3_tc;
  wire [`TC_W-1:0] next_a2_tc;

  // strict ordering, forced whenever relaxed writes are disabled
  always @*
  begin
    next_strict = ~relax_en;
    if (relax_en && s1_wr && s1_flags[`FLG_STRICT_ORDER])
      next_strict = 1'b1;
  end

  // ---------------------------------------------------------------
  // per stream class selection: 0 completion, 1 third, 2 second address
  // ---------------------------------------------------------------
  wire [2:0]          strm_use;
  wire [2:0]          strm_sel;
  wire [3*`TC_W-1:0]  strm_tc;

  // stream meaningful flags and raw selector bits, same order
  assign strm_use = {a2_use, a3_use, cr_use};
  assign strm_sel = {s1_flags[`FLG_ADDR2_TC_SEL], s1_flags[`FLG_ADDR3_TC_SEL],
                     s1_flags[`FLG_CR_TC_SEL]};

  // a reserved or unused selector falls back to the first class
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs = gs + 1)
    begin : g_stream
      assign strm_tc[gs*`TC_W +: `TC_W] = (strm_use[gs] && strm_sel[gs]) ? tc_second : tc_first;
    end
  endgenerate

  // unpack the per stream classes
  assign next_cr_tc = strm_tc[0*`TC_W +: `TC_W];
  assign next_a3_tc = strm_tc[1*`TC_W +: `TC_W];
  assign next_a2_tc = strm_tc[2*`TC_W +: `TC_W];

  // register the decode result
  always @(posedge clk)
  begin
    if (rst)
    begin
      out_valid      <= 1'b0;
      out_opcode     <= 8'h00;
      out_op_flags   <= 8'h00;
      out_cache_ctl2 <= 1'b0;
      out_strict     <= 1'b1;
      out_cr_fenced  <= 1'b1;
      out_cr_tc_used <= 1'b0;
      out_cr_tc      <= {`TC_W{1'b0}};
      out_a3_tc_used <= 1'b0;
      out_a3_tc      <= {`TC_W{1'b0}};
      out_a2_tc_used <= 1'b0;
      out_a2_tc      <= {`TC_W{1'b0}};
    end
    else
    begin
      out_valid <= s1_valid;
      if (s1_valid)
      begin
        out_opcode     <= s1_op;
        out_op_flags   <= s1_flags[`FLG_OPSPEC_HI:`FLG_OPSPEC_LO];
        out_cache_ctl2 <= s1_wr & s1_flags[`FLG_CACHE_CTL2];
        out_strict     <= next_strict;
        out_cr_fenced  <= 1'b1;
        out_cr_tc_used <= cr_use;
        out_cr_tc      <= next_cr_tc;
        out_a3_tc_used <= a3_use;
        out_a3_tc      <= next_a3_tc;
        out_a2_tc_used <= a2_use;
        out_a2_tc      <= next_a2_tc;
      end
    end
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  wire st_clr = reg_wr && status_hit && reg_wdata[`STAT_RSVD_VIOL];
  wire st_set = s1_valid && s1_flags[`FLG_RSVD_BIT];

  // control, sticky status, counter and readback
  always @(posedge clk)
  begin
    if (rst)
    begin
      relax_en      <= `CTRL_RESET;
      rsvd_viol     <= 1'b0;
      desc_count    <= {`COUNT_W{1'b0}};
      rd_reg        <= 32'h00000000;
      rd_from_table <= 1'b0;
    end
    else
    begin
      if (reg_wr && ctrl_hit)
        relax_en <= reg_wdata[`CTRL_RELAX_EN];
      // a new violation wins over a clear in the same cycle
      if (st_set)
        rsvd_viol <= 1'b1;
      else if (st_clr)
        rsvd_viol <= 1'b0;
      if (s1_valid)
        desc_count <= desc_count + {{(`COUNT_W-1){1'b0}}, 1'b1};
      rd_from_table <= reg_rd && grp_hit;
      rd_reg        <= 32'h00000000;
      if (reg_rd)
      begin
        case (reg_addr)
          `REG_CTRL:   rd_reg <= {31'h0, relax_en};
          `REG_STATUS: rd_reg <= {31'h0, rsvd_viol};
          `REG_COUNT:  rd_reg <= {16'h0000, desc_count};
          default:     rd_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // table readback comes from the table's own read register
  assign reg_rdata = rd_from_table ?
                     {25'h0, tbl_b[2*`TC_W-1:`TC_W], 1'b0, tbl_b[`TC_W-1:0]} : rd_reg;

endmodule // descriptor_flags_decoder

// ===== test/flags_decoder_props.sv
`timescale 1ns/1ns
`include "flags_decoder_consts.vh"

module flags_decoder_props (
  input wire               clk,            // clock
  input wire               rst,            // reset
  input wire [`ADDR_W-1:0] reg_addr,       // address
  input wire [31:0]        reg_wdata,      // write data
  input wire               reg_wr,         // write
  input wire               reg_rd,         // read
  input wire [31:0]        reg_rdata,      // read data
  input wire               desc_valid,     // descriptor
  input wire [63:0]        desc_word0,     // bytes 0..7
  input wire               cr_addr_valid,  // cr valid
  input wire               read_seed,      // seed read
  input wire               out_valid,      // result
  input wire [7:0]         out_opcode,     // operation
  input wire [7:0]         out_op_flags,   // op flags
  input wire               out_cache_ctl2, // hint
  input wire               out_strict,     // strict
  input wire               out_cr_fenced,  // fence
  input wire               out_cr_tc_used, // cr used
  input wire               out_a3_tc_used, // a3 used
  input wire               out_a2_tc_used, // a2 used
  input wire [`TC_W-1:0]   out_a2_tc       // a2 class
);
  reg relax;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the relaxed-order enable
  always @(posedge clk)
    if (rst)
      relax <= 1'b1;
    else if (reg_wr && reg_addr == `REG_CTRL)
      relax <= reg_wdata[`CTRL_RELAX_EN];
  result_lat_a: assert property (desc_valid |-> ##2 out_valid) else $error("late result");
  no_spur_a: assert property (out_valid |-> $past(desc_valid, 2)) else $error("stray result");
  opcode_a: assert property (out_valid |-> out_opcode == $past(desc_word0[63:56], 2)) else $error("opcode");
  op_flags_a: assert property (out_valid |-> out_op_flags == $past(desc_word0[55:48], 2)) else $error("flags");
  cr_fence_a: assert property (out_cr_fenced) else $error("no fence");
  cr_used_a: assert property (out_valid |-> out_cr_tc_used == $past(cr_addr_valid, 2)) else $error("cr used");
  force_strict_a: assert property (out_valid && !$past(relax) |-> out_strict) else $error("not strict");
  noop_hint_a: assert property (out_valid && $past(relax) && $past(desc_word0[63:56], 2) == `OP_NOOP
    |-> !out_strict && !out_cache_ctl2) else $error("noop flags");
  seed_off_a: assert property (out_valid && $past(desc_word0[63:56], 2) == `OP_CRC_GEN && !$past(read_seed, 2)
    |-> !out_a3_tc_used) else $error("seed class");
  move_sel_a: assert property (out_valid && $past(desc_word0[63:56], 2) == `OP_MEM_MOVE
    |-> out_a2_tc_used && !out_a3_tc_used) else $error("move class");
  hold_tc_a: assert property (!out_valid && !$past(rst) |-> $stable(out_a2_tc)) else $error("class moved");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata");
  strict_c: cover property (out_valid && out_strict);
  a3_c: cover property (out_valid && out_a3_tc_used);
  read_c: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule // flags_decoder_props

bind descriptor_flags_decoder flags_decoder_props u_props (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .desc_valid, .desc_word0, .cr_addr_valid, .read_seed, .out_valid, .out_opcode, .out_op_flags,
  .out_cache_ctl2, .out_strict, .out_cr_fenced, .out_cr_tc_used, .out_a3_tc_used, .out_a2_tc_used, .out_a2_tc);

// ===== test/desc_source.sv
`timescale 1ns/1ns
`include "flags_decoder_consts.vh"

module desc_source (
  input  wire             clk,           // core clock
  output reg              desc_valid,    // descriptor strobe
  output reg [63:0]       desc_word0,    // bytes 0..7
  output reg              cr_addr_valid, // cr address valid
  output reg              read_seed,     // seed option
  output reg [`WQ_W-1:0]  work_queue     // target queue
);
  // quiet lines at time zero
  initial
  begin
    desc_valid = 1'b0;
    desc_word0 = 64'h0;
    cr_addr_valid = 1'b0;
    read_seed = 1'b0;
    work_queue = 3'h0;
  end
  // one descriptor for one cycle; bit 15 stays clear unless bad is asked
  task send(input [7:0] op, input [23:0] f, input bad, input crv, input seed, input [`WQ_W-1:0] wq);
    begin
      desc_valid <= 1'b1;
      desc_word0 <= {op, f[23:16], bad, f[14:0], 32'h0};
      cr_addr_valid <= crv;
      read_seed <= seed;
      work_queue <= wq;
      @(posedge clk);
    end
  endtask
  // released lines flip so a stale value never passes for a fresh one
  task idle;
    begin
      desc_valid <= 1'b0;
      desc_word0 <= ~desc_word0;
      cr_addr_valid <= ~cr_addr_valid;
      read_seed <= ~read_seed;
      work_queue <= ~work_queue;
      @(posedge clk);
    end
  endtask
endmodule // desc_source

// ===== test/test_descriptor_flags_decoder.sv
`timescale 1ns/1ns
`include "flags_decoder_consts.vh"

module test_descriptor_flags_decoder;
  reg                clk, rst, reg_wr, reg_rd, relax;
  reg [`ADDR_W-1:0]  reg_addr;
  reg [31:0]         reg_wdata;
  reg [5:0]          tbl [0:7];
  reg [31:0]         exq [$];
  wire [31:0]        reg_rdata;
  wire [63:0]        desc_word0;
  wire [7:0]         out_opcode, out_op_flags;
  wire [`WQ_W-1:0]   work_queue;
  wire [`TC_W-1:0]   out_cr_tc, out_a3_tc, out_a2_tc;
  wire               desc_valid, cr_addr_valid, read_seed, out_valid, out_cache_ctl2, out_strict;
  wire               out_cr_fenced, out_cr_tc_used, out_a3_tc_used, out_a2_tc_used;
  integer            n_mismatch = 0, n_compared = 0, n_desc = 0, i;

  desc_source src (.clk(clk), .desc_valid(desc_valid), .desc_word0(desc_word0), .cr_addr_valid(cr_addr_valid),
    .read_seed(read_seed), .work_queue(work_queue));
  descriptor_flags_decoder dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_valid(desc_valid), .desc_word0(desc_word0),
    .cr_addr_valid(cr_addr_valid), .read_seed(read_seed), .work_queue(work_queue), .out_valid(out_valid),
    .out_opcode(out_opcode), .out_op_flags(out_op_flags), .out_cache_ctl2(out_cache_ctl2), .out_strict(out_strict),
    .out_cr_fenced(out_cr_fenced), .out_cr_tc_used(out_cr_tc_used), .out_cr_tc(out_cr_tc),
    .out_a3_tc_used(out_a3_tc_used), .out_a3_tc(out_a3_tc), .out_a2_tc_used(out_a2_tc_used), .out_a2_tc(out_a2_tc));

  task test_done;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // packed expectation: op, op flags, hint, strict, then used/class per stream
  function [31:0] exp_res(input [7:0] op, input [23:0] f, input crv, input seed, input [2:0] wq);
    reg w, d2, d3;
    begin
      w = op inside {8'h03, 8'h04, 8'h07, 8'h08, 8'h09, 8'h11, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h1A,
        8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h23, 8'h24};
      d2 = w || op == 8'h02 || op == 8'h05;
      d3 = (op inside {8'h07, 8'h09, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E}) || (op[7:1] == 7'h08 && seed);
      exp_res = {2'h0, op, f[23:16], f[14] & w, !relax | (f[13] & w), crv, (crv & f[12]) ? tbl[wq][5:3] :
        tbl[wq][2:0], d3, (d3 & f[11]) ? tbl[wq][5:3] : tbl[wq][2:0], d2, (d2 & f[10]) ? tbl[wq][5:3] : tbl[wq][2:0]};
    end
  endfunction
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      @(posedge clk);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge clk);
    end
  endtask
  task sd(input [7:0] op, input [23:0] f, input bad, input crv, input seed);
    begin
      exq.push_back(exp_res(op, f, crv, seed, op[2:0]));
      n_desc = n_desc + 1;
      src.send(op, f, bad, crv, seed, op[2:0]);
    end
  endtask
  task drain;
    begin
      src.idle;
      for (i = 0; i < 20 && exq.size() != 0; i = i + 1) @(posedge clk);
      chk(exq.size(), 0);
    end
  endtask
  // every result against the oldest expectation
  always @(posedge clk)
    if (out_valid === 1'b1)
      chk({2'h0, out_opcode, out_op_flags, out_cache_ctl2, out_strict, out_cr_tc_used, out_cr_tc, out_a3_tc_used,
        out_a3_tc, out_a2_tc_used, out_a2_tc}, exq.size() ? exq.pop_front() : 32'hFFFFFFFF);

  task t_regs;
    begin
      rdc(`REG_CTRL, 32'h1);
      rdc(`REG_COUNT, 32'h0);
      rdc(8'h10, 32'h0);
      for (int k = 0; k < 8; k++)
      begin
        tbl[k] = {3'(7 - k), 3'(k)};
        wr(`REG_GRP_BASE + 8'(4 * k), {25'h0, tbl[k][5:3], 1'b0, tbl[k][2:0]});
        rdc(`REG_GRP_BASE + 8'(4 * k), {25'h0, tbl[k][5:3], 1'b0, tbl[k][2:0]});
      end
      $display("register test done");
    end
  endtask
  // every code back to back, selectors set then clear, both seed and cr settings
  task t_codes;
    begin
      for (int k = 0; k <= 8'h26; k++)
      begin
        sd(8'(k), {8'(k), 16'h7C00}, 1'b0, k[0], !k[1]);
        sd(8'(k), {~8'(k), 16'h0000}, 1'b0, !k[0], k[1]);
      end
      drain;
      $display("code test done");
    end
  endtask
  task t_strict;
    begin
      wr(`REG_CTRL, 32'h0);
      relax = 1'b0;
      sd(`OP_MEM_MOVE, 24'h0, 1'b0, 1'b1, 1'b0);
      sd(`OP_NOOP, 24'h2000, 1'b0, 1'b0, 1'b0);
      drain;
      wr(`REG_CTRL, 32'h1);
      relax = 1'b1;
      $display("strict test done");
    end
  endtask
  task t_rsvd;
    begin
      rdc(`REG_STATUS, 32'h0);
      sd(`OP_REDUCE, 24'h0C00, 1'b1, 1'b1, 1'b0);
      drain;
      rdc(`REG_STATUS, 32'h1);
      wr(`REG_STATUS, 32'h1);
      rdc(`REG_STATUS, 32'h0);
      rdc(`REG_COUNT, n_desc);
      wr(`REG_CTRL, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(`REG_CTRL, 32'h1);
      rdc(`REG_COUNT, 32'h0);
      sd(`OP_DUALCAST, 24'h1C00, 1'b0, 1'b1, 1'b0);
      drain;
      $display("reserved and reset test done");
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog well beyond the two hundred or so cycles the tests need
  initial
  begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    relax = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_codes;
    t_strict;
    t_rsvd;
    test_done;
  end
endmodule // test_descriptor_flags_decoder
